// file: src/dnp_pkg.sv
package dnp_pkg;

   // ---------------------------------------------------------------
   // Register selects on the processor write port
   // ---------------------------------------------------------------
   localparam logic [1:0] SEL_ADDR_HIGH = 2'h0;
   localparam logic [1:0] SEL_ADDR_LOW  = 2'h1;
   localparam logic [1:0] SEL_CONTROL   = 2'h2;
   localparam logic [1:0] SEL_DATA      = 2'h3;

   // ---------------------------------------------------------------
   // Control register bit positions
   // ---------------------------------------------------------------
   localparam int BIT_WIPE_EN     = 6;
   localparam int BIT_WIPE_START  = 5;
   localparam int BIT_PAGE_MODE   = 4;
   localparam int BIT_PROG_EN     = 3;
   localparam int BIT_PROG_START  = 2;
   localparam int BIT_FETCH_EN    = 1;
   localparam int BIT_FETCH_START = 0;

   // ---------------------------------------------------------------
   // Geometry, reset values and counts
   // ---------------------------------------------------------------
   localparam int         ADDR_W      = 9;
   localparam int         OFFS_W      = 4;
   localparam int         PAGE_BYTES  = 16;
   localparam logic [3:0] OFFS_MAX    = 4'hf;
   localparam logic [7:0] CTRL_RESET  = 8'h00;
   localparam logic [7:0] ADDR_RESET  = 8'h00;
   localparam logic [7:0] DATA_RESET  = 8'h00;
   localparam logic [7:0] ERASED_BYTE = 8'h00;
   localparam int         CYCLE_TICKS = 16;
   localparam int         FIFO_DEPTH  = 32;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       instr;
      logic       wr;
      logic [1:0] sel;
      logic [7:0] data;
   } dnp_cpu_type;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WIPE,
      ST_PROG
   } dnp_state_type;

endpackage

// file: src/dnp_fifo.sv
`timescale 1ns/1ps
module dnp_fifo
   import dnp_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic             mclk_i,
   input  wire logic             nrst_i,
   // Filling side
   input  wire logic             in_valid_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  in_ready_o,
   // Draining side
   output logic                  out_valid_o,
   output logic [WIDTH-1:0]      out_data_o,
   input  wire logic             out_ready_i
);

   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL_CNT = DEPTH[PW:0];

   logic [WIDTH-1:0] store_q [DEPTH];
   logic [PW-1:0]    wptr_q;
   logic [PW-1:0]    wptr_d;
   logic [PW-1:0]    rptr_q;
   logic [PW-1:0]    rptr_d;
   logic [PW:0]      cnt_q;
   logic [PW:0]      cnt_d;
   logic             ready_d;
   logic             push;
   logic             pop;

   // ---------------------------------------------------------------
   // Pointer and fill bookkeeping
   // ---------------------------------------------------------------
   always_comb begin
      push    = in_valid_i && in_ready_o;
      pop     = out_ready_i && out_valid_o;
      wptr_d  = push ? PW'(wptr_q + 1'b1) : wptr_q;
      rptr_d  = pop ? PW'(rptr_q + 1'b1) : rptr_q;
      cnt_d   = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
      ready_d = cnt_d != FULL_CNT;
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         wptr_q      <= '0;
         rptr_q      <= '0;
         cnt_q       <= '0;
         in_ready_o  <= 1'b1;
      end else begin
         wptr_q      <= wptr_d;
         rptr_q      <= rptr_d;
         cnt_q       <= cnt_d;
         in_ready_o  <= ready_d;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (push) begin
         store_q[wptr_q] <= in_data_i;
      end
   end

   assign out_valid_o = cnt_q != '0;
   assign out_data_o  = store_q[rptr_q];

endmodule

// file: src/dnp_top.sv
// How it works
// - Page mode reads up to 16 bytes in sequence from the loaded address.
// - Fetch start is ignored unless fetch enable is already high.
// - Each read ends: fetch start clears, byte lands in data, page mode offset +1.
// - In page mode, setting fetch start again reads the next location without reloads.
// - Upper 5 bits are the page; only the 4-bit offset climbs, stops at 0FH.
// - Power-on reset clears the page buffer.
// - Wipe enable falling clears the page buffer; rising leaves it.
// - Program enable falling clears the page buffer; rising leaves it.
// - Each dummy data write tags its location for erasure and bumps offset.
// - Erase starts only on wipe enable then wipe start in next instruction.
// - Wipe start clears itself when the erase cycle ends.
// - After erase, wipe enable drops and erased bytes read as zero.
// - An independent timer paces cycles; completion shows on bit and event.
// - Byte write starts only on program enable then start next instruction.
// - Program start is ignored unless program enable is already high.
// - Program start clears itself when the write cycle ends.
// - Program enable drops after every completed write.
// - Byte write erases the target byte before programming it.
// - Page write takes up to 16 data writes into the buffer, offset +1.
// - Data writes after the offset saturated at 0FH are discarded.
// - Program enable is clear at power-on.
// - Control bits: 5 wipe start, 4 page, 3/2 program, 1/0 fetch.
// - Done flag rises after each erase or write; firmware clears it.
`timescale 1ns/1ps
module dnp_top
   import dnp_pkg::*;
#(
   parameter int TICKS = CYCLE_TICKS,
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic         mclk_i,
   input  wire logic         nrst_i,
   // Processor register writes
   input  wire dnp_cpu_type  cpu_i,
   input  wire logic         done_clr_i,
   // Free-running cycle timer
   input  wire logic         nv_timer_tick_i,
   // Register contents
   output logic [7:0]        nv_control_o,
   output logic [7:0]        nv_addr_high_o,
   output logic [7:0]        nv_addr_low_o,
   output logic [7:0]        nv_data_reg_o,
   // Status
   output logic              nv_done_flag_o,
   output logic              nv_done_evt_o,
   output logic              data_ready_o
);

   localparam int CW = $clog2(TICKS + 1);
   localparam logic [CW-1:0] LAST_TICK = CW'(TICKS - 1);

   // ---------------------------------------------------------------
   // Storage and state
   // ---------------------------------------------------------------
   logic [7:0]     mem_q [2**ADDR_W];
   logic [7:0]     buf_q [PAGE_BYTES];
   logic [7:0]     buf_d [PAGE_BYTES];
   logic [15:0]    tag_q;
   logic [15:0]    tag_d;
   logic           full_q;
   logic           full_d;
   logic [7:0]     ctrl_q;
   logic [7:0]     ctrl_d;
   logic [7:0]     addrh_q;
   logic [7:0]     addrh_d;
   logic [7:0]     addrl_q;
   logic [7:0]     addrl_d;
   logic [7:0]     data_q;
   logic [7:0]     data_d;
   logic           arm_w_q;
   logic           arm_w_d;
   logic           arm_p_q;
   logic           arm_p_d;
   dnp_state_type  state_q;
   dnp_state_type  state_d;
   logic [CW-1:0]  cnt_q;
   logic [CW-1:0]  cnt_d;
   logic           done_q;
   logic           done_d;
   logic           evt_q;
   logic           evt_d;
   logic           tick_s1_q;
   logic           tick_s2_q;
   logic           tick_s3_q;
   logic           tick_edge;
   logic           wipe_do;
   logic           prog_do;
   logic           fifo_valid;
   logic [7:0]     fifo_data;
   logic           fifo_pop;
   logic           fifo_push;
   logic [7:0]     w;
   logic [ADDR_W-1:0] addr;
   logic [4:0]     page;
   logic [3:0]     offs;

   function automatic logic [3:0] inc_offs(input logic [3:0] o);
      inc_offs = (o == OFFS_MAX) ? OFFS_MAX : 4'(o + 4'h1);
   endfunction

   assign addr = {addrh_q[0], addrl_q};
   assign page = addr[ADDR_W-1:OFFS_W];
   assign offs = addr[OFFS_W-1:0];
   assign w    = cpu_i.data;

   // ---------------------------------------------------------------
   // Data write queue
   // ---------------------------------------------------------------
   assign fifo_push = cpu_i.wr && (cpu_i.sel == SEL_DATA);
   assign fifo_pop  = fifo_valid && (state_q == ST_IDLE);

   dnp_fifo #(
      .WIDTH (8),
      .DEPTH (DEPTH)
   ) u_fifo (
      .mclk_i      (mclk_i),
      .nrst_i      (nrst_i),
      .in_valid_i  (fifo_push),
      .in_data_i   (cpu_i.data),
      .in_ready_o  (data_ready_o),
      .out_valid_o (fifo_valid),
      .out_data_o  (fifo_data),
      .out_ready_i (fifo_pop)
   );

   // ---------------------------------------------------------------
   // Timer tick synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         tick_s1_q <= 1'b0;
         tick_s2_q <= 1'b0;
         tick_s3_q <= 1'b0;
      end else begin
         tick_s1_q <= nv_timer_tick_i;
         tick_s2_q <= tick_s1_q;
         tick_s3_q <= tick_s2_q;
      end
   end

   assign tick_edge = tick_s2_q && !tick_s3_q;

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      ctrl_d  = ctrl_q;
      addrh_d = addrh_q;
      addrl_d = addrl_q;
      data_d  = data_q;
      buf_d   = buf_q;
      tag_d   = tag_q;
      full_d  = full_q;
      state_d = state_q;
      cnt_d   = cnt_q;
      evt_d   = 1'b0;
      wipe_do = 1'b0;
      prog_do = 1'b0;
      arm_w_d = cpu_i.instr ? 1'b0 : arm_w_q;
      arm_p_d = cpu_i.instr ? 1'b0 : arm_p_q;

      // Address loads restart the page fill.
      if (cpu_i.wr && cpu_i.sel == SEL_ADDR_HIGH) begin
         addrh_d = {7'h00, w[0]};
         full_d  = 1'b0;
      end
      if (cpu_i.wr && cpu_i.sel == SEL_ADDR_LOW) begin
         addrl_d = w;
         full_d  = 1'b0;
      end

      // Control writes; start bits are only set here, never cleared.
      if (cpu_i.wr && cpu_i.sel == SEL_CONTROL && state_q == ST_IDLE) begin
         ctrl_d[7]              = 1'b0;
         ctrl_d[BIT_WIPE_EN]    = w[BIT_WIPE_EN];
         ctrl_d[BIT_PAGE_MODE]  = w[BIT_PAGE_MODE];
         ctrl_d[BIT_PROG_EN]    = w[BIT_PROG_EN];
         ctrl_d[BIT_FETCH_EN]   = w[BIT_FETCH_EN];
         if (w[BIT_FETCH_START] && ctrl_q[BIT_FETCH_EN]) begin
            ctrl_d[BIT_FETCH_START] = 1'b1;
         end
         if (w[BIT_PROG_START] && ctrl_q[BIT_PROG_EN] && arm_p_q) begin
            ctrl_d[BIT_PROG_START] = 1'b1;
         end
         if (w[BIT_WIPE_START] && ctrl_q[BIT_WIPE_EN] && arm_w_q) begin
            ctrl_d[BIT_WIPE_START] = 1'b1;
         end
         if (w[BIT_WIPE_EN] && !ctrl_q[BIT_WIPE_EN]) begin
            arm_w_d = 1'b1;
         end
         if (w[BIT_PROG_EN] && !ctrl_q[BIT_PROG_EN]) begin
            arm_p_d = 1'b1;
         end
      end

      unique case (state_q)
         ST_IDLE: begin
            cnt_d = '0;
            if (fifo_pop) begin
               data_d = fifo_data;
               if (ctrl_q[BIT_PAGE_MODE] && !full_d) begin
                  buf_d[offs] = fifo_data;
                  tag_d[offs] = 1'b1;
                  if (offs == OFFS_MAX) begin
                     full_d = 1'b1;
                  end else begin
                     addrl_d[3:0] = inc_offs(offs);
                  end
               end
            end else if (ctrl_q[BIT_FETCH_START]) begin
               data_d = mem_q[addr];
               ctrl_d[BIT_FETCH_START] = 1'b0;
               if (ctrl_q[BIT_PAGE_MODE]) begin
                  addrl_d[3:0] = inc_offs(offs);
               end
            end else if (ctrl_q[BIT_WIPE_START]) begin
               state_d = ST_WIPE;
            end else if (ctrl_q[BIT_PROG_START]) begin
               state_d = ST_PROG;
            end
         end
         ST_WIPE,
         ST_PROG: begin
            if (tick_edge) begin
               cnt_d = CW'(cnt_q + 1'b1);
               if (cnt_q == LAST_TICK) begin
                  evt_d   = 1'b1;
                  state_d = ST_IDLE;
                  if (state_q == ST_WIPE) begin
                     wipe_do                = 1'b1;
                     ctrl_d[BIT_WIPE_START] = 1'b0;
                     ctrl_d[BIT_WIPE_EN]    = 1'b0;
                  end else begin
                     prog_do                = 1'b1;
                     ctrl_d[BIT_PROG_START] = 1'b0;
                     ctrl_d[BIT_PROG_EN]    = 1'b0;
                  end
               end
            end
         end
         default: begin
            // An unused state code falls back to idle.
            state_d = ST_IDLE;
         end
      endcase

      // A falling wipe or program enable, by software or at completion, empties the
      // buffer. The memory update this cycle still sees the old buffer.
      if ((ctrl_q[BIT_WIPE_EN] && !ctrl_d[BIT_WIPE_EN]) ||
          (ctrl_q[BIT_PROG_EN] && !ctrl_d[BIT_PROG_EN])) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            buf_d[i] = DATA_RESET;
         end
         tag_d  = '0;
         full_d = 1'b0;
      end

      done_d = evt_d || (done_q && !done_clr_i);
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         ctrl_q  <= CTRL_RESET;
         addrh_q <= ADDR_RESET;
         addrl_q <= ADDR_RESET;
         data_q  <= DATA_RESET;
         for (int i = 0; i < PAGE_BYTES; i++) begin
            buf_q[i] <= DATA_RESET;
         end
         tag_q   <= '0;
         full_q  <= 1'b0;
         arm_w_q <= 1'b0;
         arm_p_q <= 1'b0;
         state_q <= ST_IDLE;
         cnt_q   <= '0;
         done_q  <= 1'b0;
         evt_q   <= 1'b0;
      end else begin
         ctrl_q  <= ctrl_d;
         addrh_q <= addrh_d;
         addrl_q <= addrl_d;
         data_q  <= data_d;
         buf_q   <= buf_d;
         tag_q   <= tag_d;
         full_q  <= full_d;
         arm_w_q <= arm_w_d;
         arm_p_q <= arm_p_d;
         state_q <= state_d;
         cnt_q   <= cnt_d;
         done_q  <= done_d;
         evt_q   <= evt_d;
      end
   end

   // ---------------------------------------------------------------
   // Nonvolatile array update at cycle end
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (wipe_do) begin
         if (ctrl_q[BIT_PAGE_MODE]) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
               if (tag_q[i]) begin
                  mem_q[{page, 4'(i)}] <= ERASED_BYTE;
               end
            end
         end else begin
            mem_q[addr] <= ERASED_BYTE;
         end
      end else if (prog_do) begin
         if (ctrl_q[BIT_PAGE_MODE]) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
               if (tag_q[i]) begin
                  mem_q[{page, 4'(i)}] <= buf_q[i];
               end
            end
         end else begin
            // The old byte is erased and replaced in the one update.
            mem_q[addr] <= data_q;
         end
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign nv_control_o   = ctrl_q;
   assign nv_addr_high_o = addrh_q;
   assign nv_addr_low_o  = addrl_q;
   assign nv_data_reg_o  = data_q;
   assign nv_done_flag_o = done_q;
   assign nv_done_evt_o  = evt_q;

endmodule

// file: verif/dnp_top_monitor.sv
`timescale 1ns/1ps
module dnp_top_monitor
   import dnp_pkg::*;
#(
   parameter int TICKS = CYCLE_TICKS,
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input wire logic        mclk_i,
   input wire logic        nrst_i,
   // Inputs
   input wire dnp_cpu_type cpu_i,
   input wire logic        done_clr_i,
   input wire logic        nv_timer_tick_i,
   // Outputs
   input wire logic [7:0]  nv_control_o,
   input wire logic [7:0]  nv_addr_high_o,
   input wire logic [7:0]  nv_addr_low_o,
   input wire logic [7:0]  nv_data_reg_o,
   input wire logic        nv_done_flag_o,
   input wire logic        nv_done_evt_o,
   input wire logic        data_ready_o
);
   // ------
   // Checks
   // ------
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);
   wire logic [7:0] c = nv_control_o;
   wire logic [3:0] offs = nv_addr_low_o[3:0];

   AST_EVT_FLAG: assert property (nv_done_evt_o |-> nv_done_flag_o)
      else $error("done event without done flag");
   AST_EVT_IDLE: assert property (nv_done_evt_o |-> c[6:2] == 5'h00
      || c[6:2] == 5'h04) else $error("enable or start left set at end");
   AST_PROG_END: assert property ($fell(c[BIT_PROG_START])
      |-> nv_done_evt_o) else $error("program start fell without event");
   AST_WIPE_END: assert property ($fell(c[BIT_WIPE_START])
      |-> nv_done_evt_o) else $error("wipe start fell without event");
   AST_FETCH_GATE: assert property ($rose(c[BIT_FETCH_START])
      |-> $past(c[BIT_FETCH_EN])) else $error("fetch without enable");
   AST_PROG_GATE: assert property ($rose(c[BIT_PROG_START])
      |-> $past(c[BIT_PROG_EN])) else $error("write without enable");
   AST_WIPE_GATE: assert property ($rose(c[BIT_WIPE_START])
      |-> $past(c[BIT_WIPE_EN])) else $error("erase without enable");
   AST_PROG_TIME: assert property ($rose(c[BIT_PROG_START])
      |=> !nv_done_evt_o [*2] ##[1:600] nv_done_evt_o)
      else $error("write cycle length out of range");
   AST_OFFS_SAT: assert property (offs == OFFS_MAX
      && !(cpu_i.wr && cpu_i.sel == SEL_ADDR_LOW) |=> offs == OFFS_MAX)
      else $error("offset left its saturated value");
   AST_FETCH_STEP: assert property ($fell(c[BIT_FETCH_START])
      && c[BIT_PAGE_MODE] && $past(offs) != OFFS_MAX
      |-> offs == $past(offs) + 4'h1) else $error("offset step wrong");

   cover property (nv_done_evt_o && c[BIT_PAGE_MODE]);
   cover property (nv_done_evt_o && !c[BIT_PAGE_MODE]);
   cover property ($fell(c[BIT_FETCH_START]) && offs == OFFS_MAX);
endmodule

bind dnp_top dnp_top_monitor #(.TICKS(TICKS), .DEPTH(DEPTH))
   i_dnp_top_monitor (.mclk_i, .nrst_i, .cpu_i, .done_clr_i,
   .nv_timer_tick_i, .nv_control_o, .nv_addr_high_o, .nv_addr_low_o,
   .nv_data_reg_o, .nv_done_flag_o, .nv_done_evt_o, .data_ready_o);

// file: verif/dnp_cpu_model.sv
`timescale 1ns/1ps
module dnp_cpu_model
   import dnp_pkg::*;
(
   // Clock
   input  wire logic   mclk_i,
   // Core register writes and timer tick
   output dnp_cpu_type cpu_o,
   output logic        tick_o
);
   // ------
   // Cycle timer
   // ------
   // It runs free, unrelated in phase to the system clock.
   initial begin
      tick_o = 1'b0;
      forever #37 tick_o = ~tick_o;
   end
   // ------
   // Instruction cycles
   // ------
   initial cpu_o = '0;
   // One call is one instruction, held up to the edge that takes it.
   task automatic wr(input logic [1:0] s, input logic [7:0] d);
      cpu_o <= {1'b1, 1'b1, s, d};
      @(posedge mclk_i);
   endtask
   // An enable and its start go out as two back-to-back instructions,
   // as firmware does with interrupts masked, so nothing splits the pair.
   task automatic arm(input logic [7:0] en, input logic [7:0] go);
      wr(SEL_CONTROL, en);
      wr(SEL_CONTROL, go);
   endtask
   task automatic idle(input logic ins, input int n);
      cpu_o <= {ins, 11'h000};
      repeat (n) @(posedge mclk_i);
   endtask
endmodule

// file: verif/dnp_top_tb.sv
`timescale 1ns/1ps
module dnp_top_tb
   import dnp_pkg::*;
;
   // ------
   // Nets
   // ------
   logic        mclk_i;
   logic        nrst_i;
   logic        done_clr_i;
   dnp_cpu_type cpu_i;
   logic        nv_timer_tick_i;
   logic [7:0]  nv_control_o;
   logic [7:0]  nv_addr_high_o;
   logic [7:0]  nv_addr_low_o;
   logic [7:0]  nv_data_reg_o;
   logic        nv_done_flag_o;
   logic        nv_done_evt_o;
   logic        data_ready_o;
   int          err_total = 0;
   int          n_checks = 0;
   typedef struct packed {
      logic [1:0] sel;
      logic [7:0] d;
      logic [7:0] hi;
      logic [7:0] lo;
      logic [7:0] ctl;
   } dnp_row_type;
   dnp_row_type rows [8] = '{
      '{SEL_ADDR_HIGH, 8'hff, 8'h01, 8'h00, 8'h00},
      '{SEL_ADDR_LOW, 8'h3c, 8'h01, 8'h3c, 8'h00},
      '{SEL_CONTROL, 8'h10, 8'h01, 8'h3c, 8'h10},
      '{SEL_CONTROL, 8'h04, 8'h01, 8'h3c, 8'h00},
      '{SEL_CONTROL, 8'h01, 8'h01, 8'h3c, 8'h00},
      '{SEL_CONTROL, 8'h20, 8'h01, 8'h3c, 8'h00},
      '{SEL_CONTROL, 8'h02, 8'h01, 8'h3c, 8'h02},
      '{SEL_CONTROL, 8'h80, 8'h01, 8'h3c, 8'h00}};

   dnp_cpu_model i_dnp_cpu_model (.mclk_i, .cpu_o(cpu_i),
      .tick_o(nv_timer_tick_i));
   dnp_top #(.TICKS(2), .DEPTH(FIFO_DEPTH)) i_dnp_top (.mclk_i, .nrst_i,
      .cpu_i, .done_clr_i, .nv_timer_tick_i, .nv_control_o,
      .nv_addr_high_o, .nv_addr_low_o, .nv_data_reg_o, .nv_done_flag_o,
      .nv_done_evt_o, .data_ready_o);

   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end
   // ------
   // Tasks
   // ------
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic w(input logic [1:0] s, input logic [7:0] d);
      i_dnp_cpu_model.wr(s, d);
   endtask
   task automatic idl(input int n);
      i_dnp_cpu_model.idle(1'b0, n);
      #1;
   endtask
   task automatic rst_chk();
      chk("control", nv_control_o, CTRL_RESET);
      chk("addr high", nv_addr_high_o, ADDR_RESET);
      chk("addr low", nv_addr_low_o, ADDR_RESET);
      chk("data", nv_data_reg_o, DATA_RESET);
      chk("status",
         {5'h00, nv_done_flag_o, nv_done_evt_o, data_ready_o}, 8'h01);
   endtask
   task automatic wait_lo(input logic [7:0] e);
      idl(1);
      for (int i = 0; i < 100 && nv_addr_low_o !== e; i++) idl(1);
      chk("offset", nv_addr_low_o, e);
   endtask
   task automatic done_wait(input logic [7:0] e);
      idl(1);
      for (int i = 0; i < 600 && nv_done_evt_o !== 1'b1; i++) idl(1);
      chk("done", {6'h00, nv_done_evt_o, nv_done_flag_o}, 8'h03);
      chk("end control", nv_control_o, e);
   endtask
   task automatic fetch(input logic [7:0] c, e);
      w(SEL_CONTROL, c);
      idl(2);
      for (int i = 0; i < 100 && nv_control_o[0] !== 1'b0; i++) idl(1);
      chk("fetch end", nv_control_o, c & 8'hfe);
      chk("fetch data", nv_data_reg_o, e);
   endtask
   // ------
   // Sequence
   // ------
   initial begin
      int k;
      nrst_i = 1'b0;
      done_clr_i = 1'b0;
      repeat (12) @(posedge mclk_i);
      #1;
      rst_chk();
      @(posedge mclk_i);
      nrst_i <= 1'b1;
      foreach (rows[j]) begin
         w(rows[j].sel, rows[j].d);
         idl(1);
         chk("row high", nv_addr_high_o, rows[j].hi);
         chk("row low", nv_addr_low_o, rows[j].lo);
         chk("row control", nv_control_o, rows[j].ctl);
      end
      // Byte write, flag clear and read back.
      w(SEL_ADDR_LOW, 8'h23);
      w(SEL_DATA, 8'h5a);
      w(SEL_CONTROL, 8'h08);
      w(SEL_CONTROL, 8'h0c);
      done_wait(8'h00);
      done_clr_i <= 1'b1;
      idl(1);
      done_clr_i <= 1'b0;
      idl(1);
      chk("flag clear", {7'h00, nv_done_flag_o}, 8'h00);
      w(SEL_DATA, 8'h00);
      w(SEL_CONTROL, 8'h02);
      fetch(8'h03, 8'h5a);
      // Page erase of the whole page.
      w(SEL_CONTROL, 8'h10);
      w(SEL_ADDR_LOW, 8'h20);
      repeat (16) w(SEL_DATA, 8'hff);
      wait_lo(8'h2f);
      w(SEL_CONTROL, 8'h50);
      w(SEL_CONTROL, 8'h70);
      done_wait(8'h10);
      w(SEL_ADDR_LOW, 8'h23);
      w(SEL_CONTROL, 8'h12);
      fetch(8'h13, ERASED_BYTE);
      // Page write with two writes past the end.
      w(SEL_CONTROL, 8'h10);
      w(SEL_ADDR_LOW, 8'h20);
      for (k = 0; k < 18; k++) w(SEL_DATA, 8'h80 + 8'(k));
      wait_lo(8'h2f);
      w(SEL_CONTROL, 8'h18);
      w(SEL_CONTROL, 8'h1c);
      done_wait(8'h10);
      w(SEL_ADDR_LOW, 8'h20);
      w(SEL_CONTROL, 8'h12);
      for (k = 0; k < 17; k++) begin
         fetch(8'h13, 8'h80 + 8'(k < 16 ? k : 15));
         chk("page offset", nv_addr_low_o, 8'h21 + 8'(k < 14 ? k : 14));
      end
      // Late start is refused; enable fall empties the buffer.
      w(SEL_ADDR_LOW, 8'h20);
      w(SEL_DATA, 8'h11);
      w(SEL_CONTROL, 8'h18);
      i_dnp_cpu_model.idle(1'b1, 1);
      w(SEL_CONTROL, 8'h1c);
      idl(1);
      chk("late start", nv_control_o, 8'h18);
      w(SEL_CONTROL, 8'h10);
      w(SEL_CONTROL, 8'h18);
      w(SEL_CONTROL, 8'h1c);
      done_wait(8'h10);
      w(SEL_ADDR_LOW, 8'h20);
      w(SEL_CONTROL, 8'h12);
      fetch(8'h13, 8'h80);
      // A software fall of wipe enable drops the tag, so nothing is erased.
      w(SEL_ADDR_LOW, 8'h20);
      w(SEL_DATA, 8'h11);
      w(SEL_CONTROL, 8'h50);
      w(SEL_CONTROL, 8'h10);
      i_dnp_cpu_model.arm(8'h50, 8'h70);
      done_wait(8'h10);
      w(SEL_ADDR_LOW, 8'h20);
      w(SEL_CONTROL, 8'h12);
      fetch(8'h13, 8'h80);
      // Reset in mid-run; a buffered byte must not survive it.
      w(SEL_ADDR_LOW, 8'h20);
      w(SEL_DATA, 8'h22);
      idl(2);
      nrst_i <= 1'b0;
      idl(2);
      rst_chk();
      nrst_i <= 1'b1;
      w(SEL_ADDR_HIGH, 8'h01);
      w(SEL_ADDR_LOW, 8'h20);
      i_dnp_cpu_model.arm(8'h18, 8'h1c);
      done_wait(8'h10);
      w(SEL_CONTROL, 8'h12);
      fetch(8'h13, 8'h80);
      end_of_test();
   end

   initial begin
      repeat (30000) @(posedge mclk_i);
      err_total++;
      end_of_test();
   end
endmodule
